// ---- hw/compare_pwm_unit.sv ----
// Design decisions made here: the register offsets and register access over APB.
`include "compare_pwm_defs.svh"
`default_nettype none

module compare_pwm_unit (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // register bus
  input  wire compare_pwm_pkg::apb_req_type apbReq,
  output var  compare_pwm_pkg::apb_rsp_type apbRsp,
  // system side
  input  wire logic                         sleepReq,
  input  wire logic                         converterEnable,
  input  wire logic                         captureExtClock,
  input  wire logic                         capturePin,
  // outputs
  output var  compare_pwm_pkg::pin_type     pinDrive,
  output var  logic                         converterStart
);
  import compare_pwm_pkg::*;

  logic [3:0]  mode_q;
  logic [1:0]  dutyLow_q;
  logic [7:0]  compareLow_q;
  logic [7:0]  compareHigh_q;
  logic [7:0]  periodReg_q;
  logic [1:0]  prescale_q;
  logic        timerOn_q;
  logic [7:0]  periodTimer_q;
  logic [7:0]  subCount_q;
  logic [1:0]  dutyLatch_q;
  logic [15:0] captureCount_q;
  logic        eventFlag_q;
  logic        captureOvf_q;
  logic        periodFlag_q;
  logic        pinDirection_q;
  logic        captureSrc_q;
  logic        captureOn_q;
  logic        matchPrev_q;
  logic        resetPending_q;
  logic        outLatch_q;
  logic        pinOe_q;
  logic        converterStart_q;
  logic [1:0]  quarter_q;
  apb_rsp_type apbRsp_q;
  logic [2:0]  sync_q [2];
  logic [1:0]  level_q;
  logic [1:0]  levelPrev_q;

  function automatic logic isMapped(input logic [7:0] addr);
    return addr == `OFS_CHANNEL_CONTROL || addr == `OFS_COMPARE_LOW || addr == `OFS_COMPARE_HIGH ||
           addr == `OFS_PERIOD_REGISTER || addr == `OFS_TIMER_CONTROL || addr == `OFS_PERIOD_TIMER ||
           addr == `OFS_CAPTURE_COUNT || addr == `OFS_STATUS || addr == `OFS_PIN_CONFIG;
  endfunction

  function automatic logic isCompare(input logic [3:0] m);
    return m == MODE_TOGGLE || m == MODE_SET || m == MODE_CLEAR || m == MODE_SWINT || m == MODE_TRIGGER;
  endfunction

  function automatic logic drivesPin(input logic [3:0] m);
    return m == MODE_TOGGLE || m == MODE_SET || m == MODE_CLEAR || m[3:2] == 2'b11;
  endfunction

  // last value of the sub-count: 4, 16, 64 or 256 oscillator cycles per prescaled step
  function automatic logic [7:0] subLimit(input logic [1:0] p);
    unique case (p)
      2'b00: return 8'h03;
      2'b01: return 8'h0F;
      2'b10: return 8'h3F;
      2'b11: return 8'hFF;
    endcase
  endfunction

  function automatic logic [1:0] lowBits(input logic [7:0] s, input logic [1:0] p);
    unique case (p)
      2'b00: return s[1:0];
      2'b01: return s[3:2];
      2'b10: return s[5:4];
      2'b11: return s[7:6];
    endcase
  endfunction

  // bus decode
  logic        setupPhase;
  logic        writeAccess;
  logic [31:0] wdata;
  assign setupPhase  = apbReq.psel && !apbReq.penable;
  assign writeAccess = apbReq.psel && apbReq.penable && apbRsp_q.pready && apbReq.pwrite && isMapped(apbReq.paddr);
  assign wdata       = apbReq.pwdata;

  logic wrControl;
  logic wrLow;
  logic wrHigh;
  logic wrCount;
  logic wrPeriodTimer;
  logic wrZeroControl;
  assign wrControl     = writeAccess && apbReq.paddr == `OFS_CHANNEL_CONTROL;
  assign wrLow         = writeAccess && apbReq.paddr == `OFS_COMPARE_LOW;
  assign wrHigh        = writeAccess && apbReq.paddr == `OFS_COMPARE_HIGH;
  assign wrCount       = writeAccess && apbReq.paddr == `OFS_CAPTURE_COUNT;
  assign wrPeriodTimer = writeAccess && apbReq.paddr == `OFS_PERIOD_TIMER;
  assign wrZeroControl = wrControl && wdata[5:0] == 6'h00;

  logic pwmMode;
  logic captureMode;
  assign pwmMode     = mode_q[3:2] == 2'b11;
  assign captureMode = mode_q[3:2] == 2'b01;

  // external capture clock and capture pin pass three flops and then a level flop that updates only when the last two agree
  logic [1:0] rawIn;
  assign rawIn = {capturePin, captureExtClock};
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        sync_q[g]      <= 3'b000;
        level_q[g]     <= 1'b0;
        levelPrev_q[g] <= 1'b0;
      end else begin
        sync_q[g]      <= {sync_q[g][1:0], rawIn[g]};
        if (sync_q[g][1] == sync_q[g][2]) begin
          level_q[g] <= sync_q[g][2];
        end
        levelPrev_q[g] <= level_q[g];
      end
    end
  end

  logic extTick;
  logic captureEvent;
  assign extTick      = level_q[0] && !levelPrev_q[0];
  assign captureEvent = captureMode && (mode_q == MODE_CAP_FALL ? (!level_q[1] && levelPrev_q[1])
                                                                : (level_q[1] && !levelPrev_q[1]));

  // instruction clock stops in sleep
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      quarter_q <= 2'b00;
    end else begin
      quarter_q <= quarter_q + 2'b01;
    end
  end

  logic instrTick;
  logic countTick;
  assign instrTick = quarter_q == 2'(`INSTR_CLOCK_DIV - 1) && !sleepReq;
  assign countTick = captureOn_q && (captureSrc_q ? extTick : instrTick);

  // compare path
  logic match;
  logic matchEvent;
  logic resetNow;
  assign match      = captureCount_q == {compareHigh_q, compareLow_q};
  assign matchEvent = isCompare(mode_q) && match && !matchPrev_q && !sleepReq;
  assign resetNow   = resetPending_q && countTick && match;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      matchPrev_q      <= 1'b0;
      resetPending_q   <= 1'b0;
      converterStart_q <= 1'b0;
    end else begin
      matchPrev_q      <= match && isCompare(mode_q);
      converterStart_q <= matchEvent && mode_q == MODE_TRIGGER && converterEnable;
      if (mode_q != MODE_TRIGGER) begin
        resetPending_q <= 1'b0;
      end else if (matchEvent) begin
        resetPending_q <= 1'b1;
      end else if (countTick) begin
        resetPending_q <= 1'b0;
      end
    end
  end

  // capture timer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      captureCount_q <= 16'h0000;
    end else if (wrCount) begin
      captureCount_q <= wdata[15:0];
    end else if (resetNow) begin
      captureCount_q <= 16'h0000;
    end else if (countTick) begin
      captureCount_q <= captureCount_q + 16'h0001;
    end
  end

  // period timer with prescaler; the top two bits of the sub-count's range extend the time base
  logic       subWrap;
  logic       periodEnd;
  logic       baseMatch;
  logic [7:0] subNext;
  logic [7:0] timerNext;
  // wrap at or above the limit, so a smaller prescale never lets the sub-count run away
  assign subWrap   = timerOn_q && !sleepReq && subCount_q >= subLimit(prescale_q);
  assign periodEnd = subWrap && periodTimer_q == periodReg_q;
  // next cycle's time base, so the registered pin is low once the base equals the duty
  assign subNext   = subWrap ? 8'h00 : subCount_q + 8'h01;
  assign timerNext = periodEnd ? 8'h00 : (subWrap ? periodTimer_q + 8'h01 : periodTimer_q);
  assign baseMatch = pwmMode && timerOn_q && !sleepReq &&
                     {timerNext, lowBits(subNext, prescale_q)} == {compareHigh_q, dutyLatch_q};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      subCount_q    <= 8'h00;
      periodTimer_q <= 8'h00;
    end else begin
      if (timerOn_q && !sleepReq) begin
        subCount_q <= subWrap ? 8'h00 : subCount_q + 8'h01;
      end
      if (wrPeriodTimer) begin
        periodTimer_q <= wdata[7:0];
      end else if (periodEnd) begin
        periodTimer_q <= 8'h00;
      end else if (subWrap) begin
        periodTimer_q <= periodTimer_q + 8'h01;
      end
    end
  end

  // compare pair and duty double buffer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      compareLow_q  <= 8'h00;
      compareHigh_q <= 8'h00;
      dutyLatch_q   <= 2'b00;
    end else begin
      if (captureEvent) begin
        compareLow_q <= captureCount_q[7:0];
      end else if (wrLow) begin
        compareLow_q <= wdata[7:0];
      end
      if (captureEvent) begin
        compareHigh_q <= captureCount_q[15:8];
      end else if (pwmMode && periodEnd) begin
        compareHigh_q <= compareLow_q;
      end else if (wrHigh && !pwmMode) begin
        compareHigh_q <= wdata[7:0];
      end
      if (mode_q == MODE_OFF) begin
        dutyLatch_q <= 2'b00;
      end else if (pwmMode && periodEnd) begin
        dutyLatch_q <= dutyLow_q;
      end
    end
  end

  // output latch shared by compare and pwm
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outLatch_q <= 1'b0;
    end else if (wrZeroControl || mode_q == MODE_OFF) begin
      outLatch_q <= 1'b0;
    end else if (pwmMode) begin
      if (periodEnd) begin
        outLatch_q <= {compareLow_q, dutyLow_q} != 10'h000;
      end else if (baseMatch) begin
        outLatch_q <= 1'b0;
      end
    end else if (matchEvent) begin
      unique case (mode_q)
        MODE_SET:    outLatch_q <= 1'b1;
        MODE_CLEAR:  outLatch_q <= 1'b0;
        MODE_TOGGLE: outLatch_q <= !outLatch_q;
        default:     outLatch_q <= outLatch_q;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinOe_q <= 1'b0;
    end else begin
      pinOe_q <= !pinDirection_q && drivesPin(mode_q);
    end
  end

  // software-written control
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q         <= `MODE_RESET;
      dutyLow_q      <= 2'b00;
      periodReg_q    <= `PERIOD_REGISTER_RESET;
      prescale_q     <= 2'b00;
      timerOn_q      <= 1'b0;
      pinDirection_q <= `PIN_DIRECTION_RESET;
      captureSrc_q   <= 1'b0;
      captureOn_q    <= 1'b0;
    end else if (writeAccess) begin
      unique case (apbReq.paddr)
        `OFS_CHANNEL_CONTROL: begin
          mode_q    <= wdata[`MODE_LSB +: 4];
          dutyLow_q <= wdata[`DUTY_LOW_LSB +: 2];
        end
        `OFS_PERIOD_REGISTER: periodReg_q <= wdata[7:0];
        `OFS_TIMER_CONTROL: begin
          prescale_q <= wdata[`PRESCALE_LSB +: 2];
          timerOn_q  <= wdata[`TIMER_ON_BIT];
        end
        `OFS_PIN_CONFIG: begin
          pinDirection_q <= wdata[`PIN_DIRECTION_BIT];
          captureSrc_q   <= wdata[`CAPTURE_SRC_BIT];
          captureOn_q    <= wdata[`CAPTURE_ON_BIT];
        end
        default: ;
      endcase
    end
  end

  // sticky status, write one to clear, a set in the same cycle wins
  logic [2:0] clearMask;
  assign clearMask = (writeAccess && apbReq.paddr == `OFS_STATUS) ? wdata[2:0] : 3'b000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eventFlag_q  <= 1'b0;
      captureOvf_q <= 1'b0;
      periodFlag_q <= 1'b0;
    end else begin
      eventFlag_q  <= (matchEvent || captureEvent) || (eventFlag_q && !clearMask[`EVENT_FLAG_BIT]);
      captureOvf_q <= (countTick && !resetNow && captureCount_q == 16'hFFFF && !wrCount) ||
                      (captureOvf_q && !clearMask[`CAPTURE_OVF_BIT]);
      periodFlag_q <= periodEnd || (periodFlag_q && !clearMask[`PERIOD_FLAG_BIT]);
    end
  end

  // bus answer: no wait states, data sampled in the setup cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      apbRsp_q <= '0;
    end else begin
      apbRsp_q.pready  <= setupPhase;
      apbRsp_q.pslverr <= setupPhase && !isMapped(apbReq.paddr);
      if (setupPhase && !apbReq.pwrite) begin
        unique case (apbReq.paddr)
          `OFS_CHANNEL_CONTROL: apbRsp_q.prdata <= {26'h0, dutyLow_q, mode_q};
          `OFS_COMPARE_LOW:     apbRsp_q.prdata <= {24'h0, compareLow_q};
          `OFS_COMPARE_HIGH:    apbRsp_q.prdata <= {24'h0, compareHigh_q};
          `OFS_PERIOD_REGISTER: apbRsp_q.prdata <= {24'h0, periodReg_q};
          `OFS_TIMER_CONTROL:   apbRsp_q.prdata <= {29'h0, timerOn_q, prescale_q};
          `OFS_PERIOD_TIMER:    apbRsp_q.prdata <= {24'h0, periodTimer_q};
          `OFS_CAPTURE_COUNT:   apbRsp_q.prdata <= {16'h0, captureCount_q};
          `OFS_STATUS:          apbRsp_q.prdata <= {29'h0, periodFlag_q, captureOvf_q, eventFlag_q};
          `OFS_PIN_CONFIG:      apbRsp_q.prdata <= {29'h0, captureOn_q, captureSrc_q, pinDirection_q};
          default:              apbRsp_q.prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign apbRsp         = apbRsp_q;
  assign pinDrive.out   = outLatch_q;
  assign pinDrive.oe    = pinOe_q;
  assign converterStart = converterStart_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_triggerMatch;
    matchEvent && mode_q == MODE_TRIGGER;
  endsequence

  sequence s_resetTick;
    resetPending_q && countTick && match && !wrCount;
  endsequence

  a_match_sets_flag: assert property (matchEvent |=> eventFlag_q)
    else $error("match did not set event flag");
  a_swint_no_pin: assert property (mode_q == MODE_SWINT && $past(mode_q) == MODE_SWINT |-> !pinOe_q)
    else $error("software interrupt mode drives pin");
  a_trigger_start: assert property (s_triggerMatch and converterEnable |=> converterStart_q ##1 !converterStart_q)
    else $error("conversion start not a single pulse");
  a_trigger_pending: assert property (s_triggerMatch |=> resetPending_q)
    else $error("timer reset not armed");
  a_reset_clears: assert property (s_resetTick |=> captureCount_q == 16'h0000 && !$rose(captureOvf_q))
    else $error("timer reset wrong");
  a_reset_cancel: assert property (resetPending_q && countTick && !match && !wrCount |=>
                                   captureCount_q == $past(captureCount_q) + 16'h0001)
    else $error("reset happened without match");
  a_zero_clears: assert property (wrZeroControl |=> !outLatch_q ##1 !outLatch_q)
    else $error("zero control write left latch high");
  a_sleep_holds: assert property (sleepReq && !captureSrc_q && !wrCount |=> $stable(captureCount_q))
    else $error("instruction clocked timer moved in sleep");
  a_period_sets: assert property (pwmMode && periodEnd && {compareLow_q, dutyLow_q} != 10'h000 && !wrControl &&
                                  !wrPeriodTimer
                                  |=> outLatch_q && periodTimer_q == 8'h00)
    else $error("period end did not set pin");
  a_duty_clears: assert property (pwmMode && baseMatch && !periodEnd && !wrControl |=> !outLatch_q)
    else $error("duty match did not clear pin");
  a_high_readonly: assert property (pwmMode && wrHigh && !periodEnd && !captureEvent |=> $stable(compareHigh_q))
    else $error("high compare register written in pwm");
  a_sleep_freeze: assert property (sleepReq && !wrPeriodTimer |=> $stable(periodTimer_q) && $stable(subCount_q))
    else $error("period timer moved in sleep");
  a_single_event: assert property (matchEvent |=> !matchEvent)
    else $error("match reported twice");

endmodule

`default_nettype wire

// ---- pkg/compare_pwm_defs.svh ----
`ifndef COMPARE_PWM_DEFS_SVH
`define COMPARE_PWM_DEFS_SVH

// register byte offsets
`define OFS_CHANNEL_CONTROL    8'h00
`define OFS_COMPARE_LOW        8'h04
`define OFS_COMPARE_HIGH       8'h08
`define OFS_PERIOD_REGISTER    8'h0C
`define OFS_TIMER_CONTROL      8'h10
`define OFS_PERIOD_TIMER       8'h14
`define OFS_CAPTURE_COUNT      8'h18
`define OFS_STATUS             8'h1C
`define OFS_PIN_CONFIG         8'h20

// field positions
`define MODE_LSB               0
`define DUTY_LOW_LSB           4
`define PRESCALE_LSB           0
`define TIMER_ON_BIT           2
`define EVENT_FLAG_BIT         0
`define CAPTURE_OVF_BIT        1
`define PERIOD_FLAG_BIT        2
`define PIN_DIRECTION_BIT      0
`define CAPTURE_SRC_BIT        1
`define CAPTURE_ON_BIT         2

// reset values
`define MODE_RESET             4'h0
`define PIN_DIRECTION_RESET    1'b1
`define PERIOD_REGISTER_RESET  8'hFF

// timing: instruction clock is the oscillator divided by four
`define INSTR_CLOCK_DIV        4

`endif

// ---- pkg/compare_pwm_pkg.sv ----
`default_nettype none

package compare_pwm_pkg;

  typedef enum logic [3:0] {
    MODE_OFF      = 4'h0,
    MODE_TOGGLE   = 4'h2,
    MODE_CAP_FALL = 4'h4,
    MODE_SET      = 4'h8,
    MODE_CLEAR    = 4'h9,
    MODE_SWINT    = 4'hA,
    MODE_TRIGGER  = 4'hB
  } chan_mode_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_type;

endpackage

`default_nettype wire

// ---- sim/far_side_model.sv ----
`default_nettype none
module far_side_model (
  // clocking
  input  wire logic mclk,
  input  wire logic extRun,
  // from block
  input  wire logic converterStart,
  // to block, and start count to testbench
  output var  logic captureExtClock,
  output var  logic capturePin,
  output var  int   startCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div;
  initial begin
    captureExtClock = 1'b0;
    capturePin = 1'b0;
    startCount = 0;
    div = 3'h0;
  end
  // slow external clock, stands still unless asked to run
  always @(posedge mclk) begin
    div <= div + 3'h1;
    if (extRun && div == 3'h7) captureExtClock <= !captureExtClock;
    if (converterStart === 1'b1) startCount <= startCount + 1;
  end
endmodule
`default_nettype wire

// ---- sim/compare_pwm_unit_tb.sv ----
`include "compare_pwm_defs.svh"
`default_nettype none
module compare_pwm_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import compare_pwm_pkg::*;
  logic        mclk, rst, sleepReq, converterEnable, extRun, err;
  logic        captureExtClock, capturePin, converterStart;
  apb_req_type apbReq;
  apb_rsp_type apbRsp;
  pin_type     pinDrive;
  int          startCount, n_errors, cmp_count, h;
  logic [31:0] rd, c0;
  typedef struct {logic [7:0] a; logic [31:0] v; logic e;} row_type;
  row_type rows [8] = '{'{`OFS_CHANNEL_CONTROL, 0, 0}, '{`OFS_PERIOD_REGISTER, 32'hFF, 0},
    '{`OFS_TIMER_CONTROL, 0, 0}, '{`OFS_PERIOD_TIMER, 0, 0}, '{`OFS_CAPTURE_COUNT, 0, 0},
    '{`OFS_STATUS, 0, 0}, '{`OFS_PIN_CONFIG, 1, 0}, '{8'h40, 0, 1}};

  compare_pwm_unit uut (.mclk(mclk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .sleepReq(sleepReq), .converterEnable(converterEnable), .captureExtClock(captureExtClock),
    .capturePin(capturePin), .pinDrive(pinDrive), .converterStart(converterStart));
  far_side_model far (.mclk(mclk), .extRun(extRun), .converterStart(converterStart),
    .captureExtClock(captureExtClock), .capturePin(capturePin), .startCount(startCount));

  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    apbReq.psel <= 1'b1;
    apbReq.pwrite <= w;
    apbReq.paddr <= a;
    apbReq.pwdata <= {24'h0, d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      stop_test();
    end
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 8'h0);
  endtask
  task automatic wait_pin(input logic v);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge mclk);
      if (pinDrive.out === v) break;
    end
    if (i == 400) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic count_high(input int n);
    h = 0;
    repeat (n) begin
      @(posedge mclk);
      if (pinDrive.out === 1'b1) h++;
    end
  endtask
  // restart the capture timer and wait past one match at count 8
  task automatic run_match();
    wr(`OFS_CAPTURE_COUNT, 8'h00);
    repeat (40) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end
  initial begin
    rst = 1'b1;
    apbReq = '0;
    sleepReq = 1'b0;
    converterEnable = 1'b0;
    extRun = 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk_bit(pinDrive.oe, 1'b0);
    foreach (rows[k]) begin
      rdr(rows[k].a);
      chk_word(rd, rows[k].v);
      chk_bit(err, rows[k].e);
    end
    wr(`OFS_COMPARE_LOW, 8'h08);
    wr(`OFS_CHANNEL_CONTROL, 8'h08);
    wr(`OFS_CAPTURE_COUNT, 8'h00);
    wr(`OFS_PIN_CONFIG, 8'h04);
    wait_pin(1'b1);
    chk_bit(pinDrive.oe, 1'b1);
    rdr(`OFS_STATUS);
    chk_bit(rd[0], 1'b1);
    wr(`OFS_STATUS, 8'h07);
    wr(`OFS_CHANNEL_CONTROL, 8'h09);
    wr(`OFS_CAPTURE_COUNT, 8'h00);
    wait_pin(1'b0);
    wr(`OFS_CHANNEL_CONTROL, 8'h02);
    wr(`OFS_CAPTURE_COUNT, 8'h00);
    wait_pin(1'b1);
    count_high(8);
    chk_word(h, 8);
    wr(`OFS_CHANNEL_CONTROL, 8'h00);
    chk_bit(pinDrive.out, 1'b0);
    wr(`OFS_STATUS, 8'h07);
    wr(`OFS_CHANNEL_CONTROL, 8'h0A);
    run_match();
    chk_bit(pinDrive.out, 1'b0);
    chk_bit(pinDrive.oe, 1'b0);
    rdr(`OFS_STATUS);
    chk_bit(rd[0], 1'b1);
    wr(`OFS_STATUS, 8'h07);
    converterEnable <= 1'b1;
    wr(`OFS_CHANNEL_CONTROL, 8'h0B);
    run_match();
    chk_word(startCount, 1);
    chk_bit(pinDrive.oe, 1'b0);
    rdr(`OFS_CAPTURE_COUNT);
    chk_bit(rd < 8, 1'b1);
    rdr(`OFS_STATUS);
    chk_bit(rd[0], 1'b1);
    chk_bit(rd[1], 1'b0);
    converterEnable <= 1'b0;
    run_match();
    chk_word(startCount, 1);
    // slow external ticks leave room to move the match away before the reset tick
    extRun <= 1'b1;
    wr(`OFS_PIN_CONFIG, 8'h06);
    wr(`OFS_CAPTURE_COUNT, 8'h00);
    converterEnable <= 1'b1;
    for (h = 0; h < 400; h++) begin
      @(posedge mclk);
      if (converterStart === 1'b1) break;
    end
    if (h == 400) begin
      n_errors++;
      stop_test();
    end
    wr(`OFS_COMPARE_LOW, 8'h20);
    repeat (16) @(posedge mclk);
    rdr(`OFS_CAPTURE_COUNT);
    chk_word(rd, 32'h0000_0009);
    wr(`OFS_CHANNEL_CONTROL, 8'h00);
    wr(`OFS_PIN_CONFIG, 8'h06);
    sleepReq <= 1'b1;
    extRun <= 1'b1;
    wr(`OFS_CAPTURE_COUNT, 8'h00);
    repeat (200) @(posedge mclk);
    rdr(`OFS_CAPTURE_COUNT);
    chk_bit(rd != 0, 1'b1);
    wr(`OFS_PIN_CONFIG, 8'h04);
    rdr(`OFS_CAPTURE_COUNT);
    c0 = rd;
    repeat (40) @(posedge mclk);
    rdr(`OFS_CAPTURE_COUNT);
    chk_word(rd, c0);
    sleepReq <= 1'b0;
    extRun <= 1'b0;
    repeat (40) @(posedge mclk);
    rdr(`OFS_CAPTURE_COUNT);
    chk_bit(rd != c0, 1'b1);
    wr(`OFS_PERIOD_REGISTER, 8'h00);
    wr(`OFS_COMPARE_LOW, 8'h00);
    wr(`OFS_CHANNEL_CONTROL, 8'h2C);
    wr(`OFS_PIN_CONFIG, 8'h01);
    wr(`OFS_TIMER_CONTROL, 8'h04);
    repeat (4) @(posedge mclk);
    rdr(`OFS_STATUS);
    chk_bit(rd[2], 1'b1);
    chk_bit(pinDrive.oe, 1'b0);
    wr(`OFS_PIN_CONFIG, 8'h00);
    wait_pin(1'b1);
    count_high(16);
    chk_word(h, 8);
    chk_bit(pinDrive.oe, 1'b1);
    wr(`OFS_COMPARE_HIGH, 8'hFF);
    rdr(`OFS_COMPARE_HIGH);
    chk_word(rd, 0);
    sleepReq <= 1'b1;
    rdr(`OFS_PERIOD_TIMER);
    c0 = rd;
    count_high(16);
    chk_bit(h == 0 || h == 16, 1'b1);
    rdr(`OFS_PERIOD_TIMER);
    chk_word(rd, c0);
    sleepReq <= 1'b0;
    wr(`OFS_CHANNEL_CONTROL, 8'h1C);
    repeat (4) @(posedge mclk);
    count_high(16);
    chk_word(h, 4);
    wr(`OFS_TIMER_CONTROL, 8'h05);
    repeat (16) @(posedge mclk);
    count_high(32);
    chk_word(h, 8);
    wr(`OFS_TIMER_CONTROL, 8'h04);
    wr(`OFS_CHANNEL_CONTROL, 8'h0C);
    repeat (8) @(posedge mclk);
    count_high(16);
    chk_word(h, 0);
    wr(`OFS_COMPARE_LOW, 8'h01);
    repeat (8) @(posedge mclk);
    count_high(16);
    chk_word(h, 16);
    stop_test();
  end
endmodule
`default_nettype wire
